// ---- design/compare_pkg.sv ----
// Constants shared by the output compare block: offsets, fields, mode codes and reset values
package compare_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CMP_ONE_LOW   = 8'h00;
  localparam logic [7:0] OFS_CMP_ONE_HIGH  = 8'h04;
  localparam logic [7:0] OFS_CTRL_ONE      = 8'h08;
  localparam logic [7:0] OFS_CMP_TWO_LOW   = 8'h0c;
  localparam logic [7:0] OFS_CMP_TWO_HIGH  = 8'h10;
  localparam logic [7:0] OFS_CTRL_TWO      = 8'h14;
  localparam logic [7:0] OFS_TIMER_B_CTRL  = 8'h18;
  localparam logic [7:0] OFS_MATCH_FLAGS   = 8'h1c;
  localparam logic [7:0] OFS_PORT_DIR      = 8'h20;
  localparam logic [7:0] OFS_PORT_DATA     = 8'h24;
  localparam int         ADDR_BITS         = 8;

  // Field positions
  localparam int MODE_LSB      = 0;
  localparam int MODE_W        = 4;
  localparam int DUTY_LSB      = 4;
  localparam int DUTY_LSB_W    = 2;
  localparam int CTRL_W        = 6;
  localparam int SEL_HIGH_BIT  = 6;
  localparam int SEL_LOW_BIT   = 3;
  localparam int FLAG_ONE_BIT  = 0;
  localparam int FLAG_TWO_BIT  = 1;
  localparam int PIN_ONE_BIT   = 2;
  localparam int PIN_TWO_BIT   = 1;

  // Reset values
  localparam logic [7:0] RST_CMP       = 8'h00;
  localparam logic [5:0] RST_CTRL      = 6'h00;
  localparam logic [7:0] RST_TIMER_B   = 8'h00;
  localparam logic [7:0] RST_PORT_DIR  = 8'hff;
  localparam logic [7:0] RST_PORT_DATA = 8'h00;

  // Mode field codes
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW  = 4'h9;
  localparam logic [3:0] MODE_SW_IRQ   = 4'ha;
  localparam logic [3:0] MODE_TRIGGER  = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP  = 2'h3;

endpackage

// ---- design/compare_unit.sv ----
// One compare/pulse-width channel: match detection and the pin output latch
`timescale 1ns/100ps
module compare_unit
  import compare_pkg::*;
#(
  parameter int CW = 16,
  parameter int DW = 10
) (
  input  wire logic          hclk,       // Core clock
  input  wire logic          hresetn,    // Async reset, active low
  input  wire logic          clk_en,     // Freezes state while low
  input  wire logic [3:0]    mode,       // Unit mode field
  input  wire logic [CW-1:0] cmp_value,  // Compare value
  input  wire logic [CW-1:0] timebase,   // Selected timer count
  input  wire logic [DW-1:0] duty,       // Pulse-width duty value
  input  wire logic [DW-1:0] pwm_count,  // Pulse-width period count
  input  wire logic          pwm_wrap,   // Period end pulse
  output logic               pin_level,  // Compare/pulse output latch
  output logic               hit         // Match event this cycle
);

  logic          pin_ff;
  logic          match_prev_ff;
  logic [3:0]    mode_prev_ff;
  logic [DW-1:0] duty_latch_ff;
  logic          is_compare;
  logic          is_pwm;
  logic          match_now;

  assign is_compare = (mode == MODE_TOGGLE) || (mode == MODE_SET_HIGH) || (mode == MODE_SET_LOW) ||
                      (mode == MODE_SW_IRQ) || (mode == MODE_TRIGGER);
  assign is_pwm     = (mode[3:2] == MODE_PWM_TOP);
  assign match_now  = is_compare && (timebase == cmp_value);
  // one event per match, not per cycle the count rests on it
  assign hit        = match_now && !match_prev_ff;
  assign pin_level  = pin_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_prev_ff <= 1'b0;
      mode_prev_ff  <= MODE_OFF;
    end else if (clk_en) begin
      match_prev_ff <= match_now;
      mode_prev_ff  <= mode;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ff        <= 1'b0;
      duty_latch_ff <= '0;
    end else if (clk_en) begin
      if (mode == MODE_OFF) begin
        pin_ff        <= 1'b0;
        duty_latch_ff <= '0;
      end else if (mode != mode_prev_ff && (mode == MODE_SET_HIGH || mode == MODE_SET_LOW)) begin
        pin_ff <= (mode == MODE_SET_LOW);
      end else if (hit) begin
        unique case (mode)
          MODE_SET_HIGH: pin_ff <= 1'b1;
          MODE_SET_LOW:  pin_ff <= 1'b0;
          MODE_TOGGLE:   pin_ff <= ~pin_ff;
          default:       pin_ff <= pin_ff;
        endcase
      end else if (is_pwm) begin
        // ten-bit duty, latched at period end
        if (pwm_wrap) begin
          duty_latch_ff <= duty;
          pin_ff        <= (duty != '0);
        end else if (pwm_count == duty_latch_ff) begin
          pin_ff <= 1'b0;
        end
      end
    end
  end

endmodule // compare_unit

// ---- design/output_compare_unit.sv ----
// Two compare/pulse-width units with AHB-Lite registers, pin sharing and special event trigger
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module output_compare_unit
  import compare_pkg::*;
#(
  parameter int CW = 16,
  parameter int DW = 10
) (
  input  wire logic          hclk,              // Core clock
  input  wire logic          hresetn,           // Async reset, active low
  input  wire logic          clk_en,            // Freezes all state while low
  input  wire logic          hsel,              // AHB slave select
  input  wire logic [31:0]   haddr,             // AHB address
  input  wire logic [1:0]    htrans,            // AHB transfer type
  input  wire logic          hwrite,            // AHB write
  input  wire logic [2:0]    hsize,             // AHB size
  input  wire logic [31:0]   hwdata,            // AHB write data
  input  wire logic          hready,            // AHB bus ready
  output logic [31:0]        hrdata,            // AHB read data
  output logic               hreadyout,         // AHB slave ready
  output logic               hresp,             // AHB response
  input  wire logic [CW-1:0] timer_a_count,     // First timer count
  input  wire logic [CW-1:0] timer_b_count,     // Second timer count
  input  wire logic [DW-1:0] pwm_count,         // Pulse-width timer with fine bits
  input  wire logic          pwm_wrap,          // Pulse-width period end
  input  wire logic          adc_enabled,       // Converter enabled
  output logic               timer_a_clear,     // Clear first timer, pulse
  output logic               timer_b_clear,     // Clear second timer, pulse
  output logic               timer_ovf_inhibit, // Clear must not set overflow flag
  output logic               adc_start,         // Start conversion, pulse
  output logic               unit_one_match_flag, // Sticky flag of unit one
  output logic               unit_two_match_flag, // Sticky flag of unit two
  output logic               unit_one_pin_out,  // Pin level, unit one
  output logic               unit_one_pin_oe,   // Pin enable, unit one
  output logic               unit_two_pin_out,  // Pin level, unit two
  output logic               unit_two_pin_oe    // Pin enable, unit two
);

  logic [7:0]           cmp_one_low_ff;
  logic [7:0]           cmp_one_high_ff;
  logic [7:0]           cmp_two_low_ff;
  logic [7:0]           cmp_two_high_ff;
  logic [CTRL_W-1:0]    unit_one_control_ff;
  logic [CTRL_W-1:0]    unit_two_control_ff;
  logic [7:0]           timer_b_control_ff;
  logic [7:0]           port_direction_bits_ff;
  logic [7:0]           shared_port_ff;
  logic                 flag_one_ff;
  logic                 flag_two_ff;
  logic                 wr_pend_ff;
  logic [ADDR_BITS-1:0] wr_addr_ff;
  logic [31:0]          hrdata_ff;
  logic                 hreadyout_ff;
  logic                 clear_a_ff;
  logic                 clear_b_ff;
  logic                 inhibit_ff;
  logic                 adc_start_ff;
  logic                 pin_one_ff;
  logic                 pin_two_ff;
  logic                 oe_one_ff;
  logic                 oe_two_ff;

  logic                 acc_valid;
  logic [ADDR_BITS-1:0] acc_addr;
  logic [31:0]          nxt_rdata;
  logic                 flag_clr_one;
  logic                 flag_clr_two;
  logic                 sel_b_one;
  logic                 sel_b_two;
  logic [CW-1:0]        base_one;
  logic [CW-1:0]        base_two;
  logic                 hit_one;
  logic                 hit_two;
  logic                 lvl_one;
  logic                 lvl_two;
  logic                 trig_one;
  logic                 trig_two;
  logic                 drive_one;
  logic                 drive_two;

  assign acc_valid = hsel && hready && htrans[1];
  assign acc_addr  = haddr[ADDR_BITS-1:0];

  // Address phase: latch write target, prepare read data so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= '0;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end else if (clk_en) begin
      hreadyout_ff <= 1'b1;
      if (hready) begin
        wr_pend_ff <= acc_valid && hwrite;
        wr_addr_ff <= acc_addr;
        hrdata_ff  <= (acc_valid && !hwrite) ? nxt_rdata : 32'h0000_0000;
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (acc_addr)
      OFS_CMP_ONE_LOW:  nxt_rdata[7:0] = cmp_one_low_ff;
      OFS_CMP_ONE_HIGH: nxt_rdata[7:0] = cmp_one_high_ff;
      OFS_CTRL_ONE:     nxt_rdata[CTRL_W-1:0] = unit_one_control_ff;
      OFS_CMP_TWO_LOW:  nxt_rdata[7:0] = cmp_two_low_ff;
      OFS_CMP_TWO_HIGH: nxt_rdata[7:0] = cmp_two_high_ff;
      OFS_CTRL_TWO:     nxt_rdata[CTRL_W-1:0] = unit_two_control_ff;
      OFS_TIMER_B_CTRL: nxt_rdata[7:0] = timer_b_control_ff;
      OFS_MATCH_FLAGS: begin
        nxt_rdata[FLAG_ONE_BIT] = flag_one_ff;
        nxt_rdata[FLAG_TWO_BIT] = flag_two_ff;
      end
      OFS_PORT_DIR:     nxt_rdata[7:0] = port_direction_bits_ff;
      OFS_PORT_DATA:    nxt_rdata[7:0] = shared_port_ff;
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Data phase writes; unmapped offsets are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_one_low_ff         <= RST_CMP;
      cmp_one_high_ff        <= RST_CMP;
      cmp_two_low_ff         <= RST_CMP;
      cmp_two_high_ff        <= RST_CMP;
      unit_one_control_ff    <= RST_CTRL;
      unit_two_control_ff    <= RST_CTRL;
      timer_b_control_ff     <= RST_TIMER_B;
      port_direction_bits_ff <= RST_PORT_DIR;
      shared_port_ff         <= RST_PORT_DATA;
    end else if (clk_en && wr_pend_ff) begin
      unique case (wr_addr_ff)
        OFS_CMP_ONE_LOW:  cmp_one_low_ff         <= hwdata[7:0];
        OFS_CMP_ONE_HIGH: cmp_one_high_ff        <= hwdata[7:0];
        OFS_CTRL_ONE:     unit_one_control_ff    <= hwdata[CTRL_W-1:0];
        OFS_CMP_TWO_LOW:  cmp_two_low_ff         <= hwdata[7:0];
        OFS_CMP_TWO_HIGH: cmp_two_high_ff        <= hwdata[7:0];
        OFS_CTRL_TWO:     unit_two_control_ff    <= hwdata[CTRL_W-1:0];
        OFS_TIMER_B_CTRL: timer_b_control_ff     <= hwdata[7:0];
        OFS_PORT_DIR:     port_direction_bits_ff <= hwdata[7:0];
        OFS_PORT_DATA:    shared_port_ff         <= hwdata[7:0];
        default:          ;
      endcase
    end
  end

  assign sel_b_one = timer_b_control_ff[SEL_HIGH_BIT];
  assign sel_b_two = timer_b_control_ff[SEL_HIGH_BIT] | timer_b_control_ff[SEL_LOW_BIT];
  assign base_one  = sel_b_one ? timer_b_count : timer_a_count;
  assign base_two  = sel_b_two ? timer_b_count : timer_a_count;

  compare_unit #(.CW(CW), .DW(DW)) u_unit_one (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .mode      (unit_one_control_ff[MODE_LSB +: MODE_W]),
    .cmp_value ({cmp_one_high_ff, cmp_one_low_ff}),
    .timebase  (base_one),
    .duty      ({cmp_one_low_ff, unit_one_control_ff[DUTY_LSB +: DUTY_LSB_W]}),
    .pwm_count (pwm_count),
    .pwm_wrap  (pwm_wrap),
    .pin_level (lvl_one),
    .hit       (hit_one)
  );

  compare_unit #(.CW(CW), .DW(DW)) u_unit_two (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .mode      (unit_two_control_ff[MODE_LSB +: MODE_W]),
    .cmp_value ({cmp_two_high_ff, cmp_two_low_ff}),
    .timebase  (base_two),
    .duty      ({cmp_two_low_ff, unit_two_control_ff[DUTY_LSB +: DUTY_LSB_W]}),
    .pwm_count (pwm_count),
    .pwm_wrap  (pwm_wrap),
    .pin_level (lvl_two),
    .hit       (hit_two)
  );

  // Software clears a flag by writing one to its bit
  assign flag_clr_one = wr_pend_ff && (wr_addr_ff == OFS_MATCH_FLAGS) && hwdata[FLAG_ONE_BIT];
  assign flag_clr_two = wr_pend_ff && (wr_addr_ff == OFS_MATCH_FLAGS) && hwdata[FLAG_TWO_BIT];

  // sticky flags, a match beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_one_ff <= 1'b0;
      flag_two_ff <= 1'b0;
    end else if (clk_en) begin
      flag_one_ff <= hit_one | (flag_one_ff & ~flag_clr_one);
      flag_two_ff <= hit_two | (flag_two_ff & ~flag_clr_two);
    end
  end

  assign trig_one = hit_one && (unit_one_control_ff[MODE_LSB +: MODE_W] == MODE_TRIGGER);
  assign trig_two = hit_two && (unit_two_control_ff[MODE_LSB +: MODE_W] == MODE_TRIGGER);

  // one-cycle timer clears on each trigger-mode match event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_a_ff   <= 1'b0;
      clear_b_ff   <= 1'b0;
      inhibit_ff   <= 1'b0;
      adc_start_ff <= 1'b0;
    end else if (clk_en) begin
      clear_a_ff   <= (trig_one && !sel_b_one) || (trig_two && !sel_b_two);
      clear_b_ff   <= (trig_one && sel_b_one) || (trig_two && sel_b_two);
      // unit two clear keeps overflow flag quiet
      inhibit_ff   <= trig_two;
      // conversion start only with converter on
      adc_start_ff <= trig_two && adc_enabled;
    end
  end

  // Capture and reserved codes leave the pin to the port latch
  assign drive_one = (unit_one_control_ff[MODE_LSB +: MODE_W] != MODE_OFF) &&
                     (unit_one_control_ff[MODE_W-1] || unit_one_control_ff[MODE_LSB +: MODE_W] == MODE_TOGGLE);
  assign drive_two = (unit_two_control_ff[MODE_LSB +: MODE_W] != MODE_OFF) &&
                     (unit_two_control_ff[MODE_W-1] || unit_two_control_ff[MODE_LSB +: MODE_W] == MODE_TOGGLE);

  // pin driven only while the direction bit is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_one_ff <= 1'b0;
      pin_two_ff <= 1'b0;
      oe_one_ff  <= 1'b0;
      oe_two_ff  <= 1'b0;
    end else if (clk_en) begin
      pin_one_ff <= drive_one ? lvl_one : shared_port_ff[PIN_ONE_BIT];
      pin_two_ff <= drive_two ? lvl_two : shared_port_ff[PIN_TWO_BIT];
      oe_one_ff  <= ~port_direction_bits_ff[PIN_ONE_BIT];
      oe_two_ff  <= ~port_direction_bits_ff[PIN_TWO_BIT];
    end
  end

  assign hrdata              = hrdata_ff;
  assign hreadyout           = hreadyout_ff;
  assign hresp               = 1'b0;
  assign timer_a_clear       = clear_a_ff;
  assign timer_b_clear       = clear_b_ff;
  assign timer_ovf_inhibit   = inhibit_ff;
  assign adc_start           = adc_start_ff;
  assign unit_one_match_flag = flag_one_ff;
  assign unit_two_match_flag = flag_two_ff;
  assign unit_one_pin_out    = pin_one_ff;
  assign unit_one_pin_oe     = oe_one_ff;
  assign unit_two_pin_out    = pin_two_ff;
  assign unit_two_pin_oe     = oe_two_ff;

endmodule // output_compare_unit

// ---- verif/output_compare_unit_sva.sv ----
// Port-level checker for the output compare block
`timescale 1ns/100ps
module output_compare_unit_sva
  import compare_pkg::*;
(
  input wire logic        hclk,                // Core clock
  input wire logic        hresetn,             // Async reset, active low
  input wire logic        hsel,                // AHB select
  input wire logic [31:0] haddr,               // AHB address
  input wire logic [1:0]  htrans,              // AHB transfer type
  input wire logic        hwrite,              // AHB write
  input wire logic [31:0] hwdata,              // AHB write data
  input wire logic        hready,              // AHB ready
  input wire logic        adc_enabled,         // Converter enabled
  input wire logic        timer_a_clear,       // Clear first timer
  input wire logic        timer_b_clear,       // Clear second timer
  input wire logic        timer_ovf_inhibit,   // Overflow flag inhibit
  input wire logic        adc_start,           // Conversion start
  input wire logic        unit_one_match_flag, // Flag of unit one
  input wire logic        unit_two_match_flag  // Flag of unit two
);
  logic flag_wr_ff;
  logic clr_one;
  logic clr_two;
  // Data phase of a write to the flag register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_wr_ff <= 1'b0;
    end else if (hready) begin
      flag_wr_ff <= hsel && htrans[1] && hwrite && (haddr[7:0] == OFS_MATCH_FLAGS);
    end
  end
  assign clr_one = flag_wr_ff && hwdata[FLAG_ONE_BIT];
  assign clr_two = flag_wr_ff && hwdata[FLAG_TWO_BIT];
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_clear_a_pulse: assert property (timer_a_clear |=> !timer_a_clear)
    else $error("first timer clear longer than one cycle");
  a_clear_b_pulse: assert property (timer_b_clear |=> !timer_b_clear)
    else $error("second timer clear longer than one cycle");
  a_clear_with_flag: assert property ((timer_a_clear || timer_b_clear) |-> (unit_one_match_flag || unit_two_match_flag))
    else $error("timer clear without a match flag");
  a_adc_needs_enable: assert property (adc_start |-> $past(adc_enabled))
    else $error("conversion started while converter disabled");
  a_adc_with_event: assert property (adc_start |-> (timer_a_clear || timer_b_clear) && unit_two_match_flag)
    else $error("conversion start without unit two event");
  a_inhibit_with_clear: assert property (timer_ovf_inhibit |-> (timer_a_clear || timer_b_clear) && unit_two_match_flag)
    else $error("overflow inhibit without unit two clear");
  a_flag_one_sticky: assert property ($fell(unit_one_match_flag) |-> $past(clr_one))
    else $error("unit one flag dropped without software clear");
  a_flag_two_sticky: assert property ($fell(unit_two_match_flag) |-> $past(clr_two))
    else $error("unit two flag dropped without software clear");
endmodule // output_compare_unit_sva

bind output_compare_unit output_compare_unit_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .adc_enabled, .timer_a_clear, .timer_b_clear, .timer_ovf_inhibit, .adc_start, .unit_one_match_flag,
  .unit_two_match_flag);

// ---- verif/timer_model.sv ----
// Behavioural model of the timers that feed the compare block
`timescale 1ns/100ps
module timer_model #(
  parameter int PWM_TOP = 255
) (
  input  wire logic        hclk,          // Core clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        run_a,         // First timer counting
  input  wire logic        run_b,         // Second timer counting
  input  wire logic        timer_a_clear, // Clear pulse, first timer
  input  wire logic        timer_b_clear, // Clear pulse, second timer
  output logic [15:0]      timer_a_count, // First timer count
  output logic [15:0]      timer_b_count, // Second timer count
  output logic [9:0]       pwm_count,     // Pulse-width count
  output logic             pwm_wrap       // Period end pulse
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_a_count <= 16'h0000;
    end else if (timer_a_clear) begin
      timer_a_count <= 16'h0000;
    end else if (run_a) begin
      timer_a_count <= timer_a_count + 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_b_count <= 16'h0000;
    end else if (timer_b_clear) begin
      timer_b_count <= 16'h0000;
    end else if (run_b) begin
      timer_b_count <= timer_b_count + 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_count <= 10'h000;
      pwm_wrap  <= 1'b0;
    end else begin
      pwm_wrap  <= (pwm_count == PWM_TOP[9:0]);
      pwm_count <= (pwm_count == PWM_TOP[9:0]) ? 10'h000 : pwm_count + 10'h001;
    end
  end
endmodule // timer_model

// ---- verif/output_compare_unit_tb.sv ----
// Testbench for the output compare block: bus tasks and match scenarios
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module output_compare_unit_tb
  import compare_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        adc_enabled = 1'b0, run_a = 1'b0, run_b = 1'b0, rdy_q;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rq, d;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, timer_a_clear, timer_b_clear, timer_ovf_inhibit, adc_start, pwm_wrap;
  logic        unit_one_match_flag, unit_two_match_flag, unit_one_pin_out, unit_one_pin_oe;
  logic        unit_two_pin_out, unit_two_pin_oe;
  logic [15:0] timer_a_count, timer_b_count;
  logic [9:0]  pwm_count;
  int          n_errors = 0, check_count = 0, n;
  logic [7:0]  ra[4] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_PORT_DIR, 8'h3c};
  logic [31:0] rv[4] = '{32'h0, 32'h0, 32'hff, 32'h0};
  logic [3:0]  md[4] = '{MODE_SET_HIGH, MODE_SW_IRQ, MODE_TOGGLE, MODE_SET_LOW};
  logic        pre[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic        post[4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  always #25 hclk = ~hclk;
  // Edge-sampled copies avoid racing the slave's own updates
  always @(posedge hclk) begin
    rq <= hrdata;
    rdy_q <= hreadyout;
  end

  output_compare_unit dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_a_count(timer_a_count), .timer_b_count(timer_b_count),
    .pwm_count(pwm_count), .pwm_wrap(pwm_wrap), .adc_enabled(adc_enabled), .timer_a_clear(timer_a_clear),
    .timer_b_clear(timer_b_clear), .timer_ovf_inhibit(timer_ovf_inhibit), .adc_start(adc_start),
    .unit_one_match_flag(unit_one_match_flag), .unit_two_match_flag(unit_two_match_flag),
    .unit_one_pin_out(unit_one_pin_out), .unit_one_pin_oe(unit_one_pin_oe),
    .unit_two_pin_out(unit_two_pin_out), .unit_two_pin_oe(unit_two_pin_oe));
  timer_model u_timers (.hclk(hclk), .hresetn(hresetn), .run_a(run_a), .run_b(run_b),
    .timer_a_clear(timer_a_clear), .timer_b_clear(timer_b_clear), .timer_a_count(timer_a_count),
    .timer_b_count(timer_b_count), .pwm_count(pwm_count), .pwm_wrap(pwm_wrap));

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge hclk);
      #1;
      if (rdy_q === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    wait_rdy();
    rd = rq;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, a, wd, dummy);
  endtask
  // Waits for first timer clear (0), second timer clear (1), unit two flag (2) or period end (3)
  task automatic wait_ev(input int which, output int cnt);
    int i;
    logic s;
    cnt = 0;
    for (i = 1; i <= 400 && cnt == 0; i++) begin
      @(posedge hclk);
      #1;
      s = (which == 0) ? timer_a_clear : (which == 1) ? timer_b_clear : (which == 2) ? unit_two_match_flag : pwm_wrap;
      if (s === 1'b1) cnt = i;
    end
    if (cnt == 0) begin
      n_errors++;
      give_verdict();
    end
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK(unit_one_pin_oe, 1'b0)
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, ra[k], 32'h0, d);
      `CHK(d, rv[k])
    end
    wr(OFS_CMP_ONE_LOW, 32'h40);
    xfer(1'b0, OFS_CMP_ONE_LOW, 32'h0, d);
    `CHK(d, 32'h40)
    // Pins become outputs only once the direction bits are cleared
    wr(OFS_PORT_DIR, 32'hf9);
    repeat (2) @(posedge hclk);
    #1;
    `CHK(unit_one_pin_oe, 1'b1)
    `CHK(unit_two_pin_oe, 1'b1)
    wr(OFS_CTRL_ONE, {28'h0, MODE_TRIGGER});
    run_a <= 1'b1;
    wait_ev(0, n);
    `CHK(unit_one_match_flag, 1'b1)
    `CHK(adc_start, 1'b0)
    `CHK(timer_ovf_inhibit, 1'b0)
    `CHK(timer_b_clear, 1'b0)
    wait_ev(0, n);
    `CHK(n, 32'h42)
    wr(OFS_MATCH_FLAGS, 32'h1);
    `CHK(unit_one_match_flag, 1'b0)
    wr(OFS_CMP_TWO_LOW, 32'h20);
    // Mode writes follow a first timer clear so the count is far below the compare value
    for (int k = 0; k < 4; k++) begin
      wait_ev(0, n);
      if (md[k] == MODE_TOGGLE) wr(OFS_CTRL_TWO, 32'h0);
      wr(OFS_CTRL_TWO, {28'h0, md[k]});
      repeat (3) @(posedge hclk);
      #1;
      `CHK(unit_two_pin_out, pre[k])
      wait_ev(2, n);
      repeat (2) @(posedge hclk);
      #1;
      `CHK(unit_two_pin_out, post[k])
      wr(OFS_MATCH_FLAGS, 32'h2);
    end
    wr(OFS_TIMER_B_CTRL, 32'h08);
    wr(OFS_CMP_TWO_LOW, 32'h30);
    wr(OFS_CTRL_TWO, {28'h0, MODE_TRIGGER});
    adc_enabled <= 1'b1;
    run_b <= 1'b1;
    wait_ev(1, n);
    `CHK(adc_start, 1'b1)
    `CHK(timer_ovf_inhibit, 1'b1)
    `CHK(unit_two_match_flag, 1'b1)
    adc_enabled <= 1'b0;
    wait_ev(1, n);
    `CHK(n, 32'h32)
    `CHK(adc_start, 1'b0)
    // Pulse-width on unit one: duty {8'h10, 2'b01} keeps the pin high for 8'h41 cycles
    wr(OFS_CTRL_ONE, 32'h1c);
    wr(OFS_CMP_ONE_LOW, 32'h10);
    wait_ev(3, n);
    repeat (8'h42) @(posedge hclk);
    #1;
    `CHK(unit_one_pin_out, 1'b1)
    @(posedge hclk);
    #1;
    `CHK(unit_one_pin_out, 1'b0)
    // Clearing the control word while the pulse is high must drop the latch
    wait_ev(3, n);
    repeat (2) @(posedge hclk);
    wr(OFS_CTRL_ONE, 32'h0);
    wr(OFS_CTRL_ONE, {28'h0, MODE_TOGGLE});
    repeat (2) @(posedge hclk);
    #1;
    `CHK(unit_one_pin_out, 1'b0)
    give_verdict();
  end
endmodule // output_compare_unit_tb
